// [bstap_defines.svh]
// constants for the boundary-scan test access port controller
// assumes inclusion by bare name from the controller, the assertions and the bench
`ifndef BSTAP_DEFINES_SVH
`define BSTAP_DEFINES_SVH

`define BSTAP_IR_W          8
`define BSTAP_BND_W         48
`define BSTAP_OPS_W         3
`define BSTAP_ID_W          32
`define BSTAP_IR_RESET      8'h81
`define BSTAP_IR_CAPTURE    8'h81
`define BSTAP_OPS_RESET     3'h2
`define BSTAP_BND_OE_HI     47
`define BSTAP_BND_OE_LO     44
`define BSTAP_OP_IDCODE     8'h81
`define BSTAP_OP_BYPASS     8'hFF
`define BSTAP_OP_BOUNDARY   8'h82
`define BSTAP_OP_OPSEL      8'h87
`define BSTAP_ID_VALUE      32'h0000_1001

`endif

// [bstap_pkg.sv]
// types for the boundary-scan test access port controller
// assumes bstap_defines.svh holds all numeric constants
package bstap_pkg;
  // the sixteen controller states
  typedef enum logic [3:0] {
    TLR, IDLE, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } bstap_state_t;
  // data register chosen by the current instruction
  typedef enum logic [1:0] {
    SEL_BYP, SEL_ID, SEL_BND, SEL_OPS
  } bstap_dsel_t;
endpackage : bstap_pkg

// [bstap_ctrl.sv]
// boundary-scan test access port controller with its test registers
// assumes tck comes from an external test bus master, mclk from the chip;
// tms and tdi are synchronous to tck and are sampled on its rising edge
`timescale 1ns/1ps
`include "bstap_defines.svh"

module bstap_ctrl #(
  parameter logic [`BSTAP_ID_W-1:0] ID_VALUE = `BSTAP_ID_VALUE // arbitrary identity value
) (
  input  wire logic                    mclk,          // system clock
  input  wire logic                    sys_rst,       // synchronous reset, active high
  input  wire logic                    clk_en,        // freezes the mclk domain while low
  input  wire logic                    tck,           // test clock, link domain
  input  wire logic                    tms,           // mode select
  input  wire logic                    tdi,           // serial data in
  output logic                         tdo,           // serial data out
  output logic                         tdo_oe,        // high while tdo is driven
  output logic [`BSTAP_BND_W-1:0]      bnd_cells,     // boundary update latches (tck)
  output logic [`BSTAP_IR_W-1:0]       instr_cur,     // current instruction (mclk)
  output logic [`BSTAP_OPS_W-1:0]      test_op_sel,   // chosen test operation (mclk)
  output logic                         test_op_run,   // test operation running (mclk)
  output logic                         test_logic_en  // controller out of reset (mclk)
);

  // ---------------- tck domain: reset crossing ----------------
  logic rst_s1_q;   // first stage, read only by the second
  logic rst_s2_q;   // synchronised reset for the tck domain
  logic rst_s1_d;
  logic rst_s2_d;

  // reset level enters the test clock domain through two stages;
  // tck may stand still, so the tms walk to reset also covers it
  // trade-off: reset reaches the tap only while tck runs, which keeps the
  // tap free of any mclk-timed logic on its own clock
  always_comb begin
    rst_s1_d = sys_rst;
    rst_s2_d = rst_s1_q;
  end

  always_ff @(posedge tck) begin
    rst_s1_q <= rst_s1_d;
    rst_s2_q <= rst_s2_d;
  end

  // ---------------- tck domain: state machine ----------------
  // tms has no synchroniser: the master launches it on the falling edge,
  // so it is already in the tck domain when the rising edge takes it
  bstap_pkg::bstap_state_t st_q; // controller state
  bstap_pkg::bstap_state_t st_d;

  // standard transition graph; six states hold, ten pass through
  always_comb begin
    st_d = st_q;
    case (st_q)
      bstap_pkg::TLR:    st_d = tms ? bstap_pkg::TLR    : bstap_pkg::IDLE;
      bstap_pkg::IDLE:   st_d = tms ? bstap_pkg::SEL_DR : bstap_pkg::IDLE;
      bstap_pkg::SEL_DR: st_d = tms ? bstap_pkg::SEL_IR : bstap_pkg::CAP_DR;
      bstap_pkg::CAP_DR: st_d = tms ? bstap_pkg::EX1_DR : bstap_pkg::SH_DR;
      bstap_pkg::SH_DR:  st_d = tms ? bstap_pkg::EX1_DR : bstap_pkg::SH_DR;
      bstap_pkg::EX1_DR: st_d = tms ? bstap_pkg::UPD_DR : bstap_pkg::PAU_DR;
      bstap_pkg::PAU_DR: st_d = tms ? bstap_pkg::EX2_DR : bstap_pkg::PAU_DR;
      bstap_pkg::EX2_DR: st_d = tms ? bstap_pkg::UPD_DR : bstap_pkg::SH_DR;
      bstap_pkg::UPD_DR: st_d = tms ? bstap_pkg::SEL_DR : bstap_pkg::IDLE;
      bstap_pkg::SEL_IR: st_d = tms ? bstap_pkg::TLR    : bstap_pkg::CAP_IR;
      bstap_pkg::CAP_IR: st_d = tms ? bstap_pkg::EX1_IR : bstap_pkg::SH_IR;
      bstap_pkg::SH_IR:  st_d = tms ? bstap_pkg::EX1_IR : bstap_pkg::SH_IR;
      bstap_pkg::EX1_IR: st_d = tms ? bstap_pkg::UPD_IR : bstap_pkg::PAU_IR;
      bstap_pkg::PAU_IR: st_d = tms ? bstap_pkg::EX2_IR : bstap_pkg::PAU_IR;
      bstap_pkg::EX2_IR: st_d = tms ? bstap_pkg::UPD_IR : bstap_pkg::SH_IR;
      bstap_pkg::UPD_IR: st_d = tms ? bstap_pkg::SEL_DR : bstap_pkg::IDLE;
      default:           st_d = bstap_pkg::TLR;
    endcase
    // any path with tms high reaches reset in at most five edges
    if (rst_s2_q) begin
      st_d = bstap_pkg::TLR;
    end
  end

  // state register, tms sampled on the rising edge
  always_ff @(posedge tck) begin
    st_q <= st_d;
  end

  // ---------------- tck domain: shift stages ----------------
  // each data register keeps its own shift stage; outside the reset state only the one
  // picked by the current instruction moves, the rest hold their last contents
  logic [`BSTAP_IR_W-1:0]  ir_sh_q;  // instruction_shift_register shift stage
  logic [`BSTAP_BND_W-1:0] bnd_sh_q; // pin_boundary_chain shift stage
  logic [`BSTAP_OPS_W-1:0] ops_sh_q; // test_operation_select_register shift stage
  logic [`BSTAP_ID_W-1:0]  id_sh_q;  // identification shift stage
  logic                    byp_q;    // bypass bit
  logic [`BSTAP_IR_W-1:0]  ir_sh_d;
  logic [`BSTAP_BND_W-1:0] bnd_sh_d;
  logic [`BSTAP_OPS_W-1:0] ops_sh_d;
  logic [`BSTAP_ID_W-1:0]  id_sh_d;
  logic                    byp_d;
  logic [`BSTAP_IR_W-1:0]  ir_cur_q; // current instruction, falling edge
  logic [`BSTAP_BND_W-1:0] bnd_up_q; // boundary update latches
  logic [`BSTAP_OPS_W-1:0] ops_up_q; // operation select update latches
  bstap_pkg::bstap_dsel_t  dsel;     // data register chosen by instruction

  // instruction decode; unknown opcodes fall back to bypass
  // the decode reads the falling-edge copy, so it never changes in the
  // middle of a capture or shift, which start and end on rising edges
  always_comb begin
    case (ir_cur_q)
      `BSTAP_OP_IDCODE:   dsel = bstap_pkg::SEL_ID;
      `BSTAP_OP_BOUNDARY: dsel = bstap_pkg::SEL_BND;
      `BSTAP_OP_OPSEL:    dsel = bstap_pkg::SEL_OPS;
      default:            dsel = bstap_pkg::SEL_BYP;
    endcase
  end

  // capture on the edge leaving capture, shift on edges inside shift;
  // the edge entering shift comes from capture, so nothing shifts there
  always_comb begin
    ir_sh_d  = ir_sh_q;
    bnd_sh_d = bnd_sh_q;
    ops_sh_d = ops_sh_q;
    id_sh_d  = id_sh_q;
    byp_d    = byp_q;
    case (st_q)
      bstap_pkg::TLR: begin
        bnd_sh_d[`BSTAP_BND_OE_HI:`BSTAP_BND_OE_LO] = '1;
        ops_sh_d = `BSTAP_OPS_RESET;
      end
      bstap_pkg::CAP_IR: ir_sh_d = `BSTAP_IR_CAPTURE;
      bstap_pkg::SH_IR:  ir_sh_d = {tdi, ir_sh_q[`BSTAP_IR_W-1:1]};
      bstap_pkg::CAP_DR: begin
        // only the selected register loads its capture source
        case (dsel)
          bstap_pkg::SEL_ID:  id_sh_d  = ID_VALUE;
          bstap_pkg::SEL_BND: bnd_sh_d = bnd_up_q;
          bstap_pkg::SEL_OPS: ops_sh_d = ops_up_q;
          default:            byp_d    = 1'b0;
        endcase
      end
      bstap_pkg::SH_DR: begin
        case (dsel)
          bstap_pkg::SEL_ID:  id_sh_d  = {tdi, id_sh_q[`BSTAP_ID_W-1:1]};
          bstap_pkg::SEL_BND: bnd_sh_d = {tdi, bnd_sh_q[`BSTAP_BND_W-1:1]};
          bstap_pkg::SEL_OPS: ops_sh_d = {tdi, ops_sh_q[`BSTAP_OPS_W-1:1]};
          default:            byp_d    = tdi;
        endcase
      end
      default: ;
    endcase
  end

  // shift stages change only on the rising edge
  always_ff @(posedge tck) begin
    ir_sh_q  <= ir_sh_d;
    bnd_sh_q <= bnd_sh_d;
    ops_sh_q <= ops_sh_d;
    id_sh_q  <= id_sh_d;
    byp_q    <= byp_d;
  end

  // ---------------- tck domain: falling-edge outputs ----------------
  // tdo_oe tells the pad when to drive; tdo simply holds its last bit
  // while released, so the pad alone decides what the line shows then
  logic [`BSTAP_IR_W-1:0]  ir_cur_d;
  logic [`BSTAP_BND_W-1:0] bnd_up_d;
  logic [`BSTAP_OPS_W-1:0] ops_up_d;
  logic                    tdo_d;
  logic                    tdo_oe_d;
  logic                    tdo_q;
  logic                    tdo_oe_q;
  logic                    upd_tgl_q; // flips when any word for mclk changes
  logic                    upd_tgl_d;
  logic                    idle_q;    // level: controller sits in idle
  logic                    tlr_q;     // level: controller sits in reset
  logic                    idle_d;
  logic                    tlr_d;

  // updates, tdo and the levels for mclk all move on the falling edge,
  // so the master always sees half a period of settled data
  always_comb begin
    ir_cur_d = ir_cur_q;
    bnd_up_d = bnd_up_q;
    ops_up_d = ops_up_q;
    tdo_d    = tdo_q;
    tdo_oe_d = 1'b0;
    case (st_q)
      bstap_pkg::TLR: begin
        ir_cur_d = `BSTAP_IR_RESET;
        bnd_up_d[`BSTAP_BND_OE_HI:`BSTAP_BND_OE_LO] = '1;
        ops_up_d = `BSTAP_OPS_RESET;
      end
      bstap_pkg::UPD_IR: ir_cur_d = ir_sh_q;
      bstap_pkg::UPD_DR: begin
        // only registers with update latches take the new value
        if (dsel == bstap_pkg::SEL_BND) begin
          bnd_up_d = bnd_sh_q;
        end else if (dsel == bstap_pkg::SEL_OPS) begin
          ops_up_d = ops_sh_q;
        end
      end
      bstap_pkg::SH_IR: begin
        tdo_d    = ir_sh_q[0];
        tdo_oe_d = 1'b1;
      end
      bstap_pkg::SH_DR: begin
        case (dsel)
          bstap_pkg::SEL_ID:  tdo_d = id_sh_q[0];
          bstap_pkg::SEL_BND: tdo_d = bnd_sh_q[0];
          bstap_pkg::SEL_OPS: tdo_d = ops_sh_q[0];
          default:            tdo_d = byp_q;
        endcase
        tdo_oe_d = 1'b1;
      end
      default: ;
    endcase
    upd_tgl_d = upd_tgl_q ^ ((ir_cur_d != ir_cur_q) || (ops_up_d != ops_up_q));
    idle_d    = (st_q == bstap_pkg::IDLE);
    tlr_d     = (st_q == bstap_pkg::TLR);
    if (rst_s2_q) begin
      // matches the state forced into reset on the same edge pair
      ir_cur_d = `BSTAP_IR_RESET;
      ops_up_d = `BSTAP_OPS_RESET;
      bnd_up_d[`BSTAP_BND_OE_HI:`BSTAP_BND_OE_LO] = '1;
      tdo_oe_d = 1'b0;
      idle_d   = 1'b0;
      tlr_d    = 1'b1;
      // the toggle needs a known level, or the mclk side never sees a change
      upd_tgl_d = 1'b0;
    end
  end

  // falling-edge register group
  always_ff @(negedge tck) begin
    ir_cur_q  <= ir_cur_d;
    bnd_up_q  <= bnd_up_d;
    ops_up_q  <= ops_up_d;
    tdo_q     <= tdo_d;
    tdo_oe_q  <= tdo_oe_d;
    upd_tgl_q <= upd_tgl_d;
    idle_q    <= idle_d;
    tlr_q     <= tlr_d;
  end

  // link outputs come straight from the falling-edge registers
  assign tdo       = tdo_q;
  assign tdo_oe    = tdo_oe_q;
  assign bnd_cells = bnd_up_q;

  // ---------------- mclk domain: crossing ----------------
  // only levels and a toggle cross through two stages; the wide words are
  // taken straight from the tck registers once the toggle has settled
  logic [2:0]              tgl_s_q;   // toggle sync, stage 0 read only by 1
  logic [1:0]              idle_s_q;  // idle level sync
  logic [1:0]              tlr_s_q;   // reset level sync
  logic [`BSTAP_IR_W-1:0]  instr_q;
  logic [`BSTAP_OPS_W-1:0] opsel_q;
  logic                    run_q;
  logic                    ten_q;
  logic [2:0]              tgl_s_d;
  logic [1:0]              idle_s_d;
  logic [1:0]              tlr_s_d;
  logic [`BSTAP_IR_W-1:0]  instr_d;
  logic [`BSTAP_OPS_W-1:0] opsel_d;
  logic                    run_d;
  logic                    ten_d;

  // words are held for several tck periods after each change, so a
  // toggle seen after two stages marks them as stable to sample
  // limitation: the stages freeze with clk_en low, so an even number of
  // updates during a freeze cancels out and the old word stays until the
  // next update; the test bus master should repeat it after a long freeze
  always_comb begin
    tgl_s_d  = {tgl_s_q[1:0], upd_tgl_q};
    idle_s_d = {idle_s_q[0], idle_q};
    tlr_s_d  = {tlr_s_q[0], tlr_q};
    instr_d  = instr_q;
    opsel_d  = opsel_q;
    if (tgl_s_q[2] != tgl_s_q[1]) begin
      instr_d = ir_cur_q;
      opsel_d = ops_up_q;
    end
    run_d = idle_s_q[1];
    ten_d = !tlr_s_q[1];
    if (sys_rst) begin
      tgl_s_d  = 3'h0;
      idle_s_d = 2'h0;
      tlr_s_d  = 2'h3;
      instr_d  = `BSTAP_IR_RESET;
      opsel_d  = `BSTAP_OPS_RESET;
      run_d    = 1'b0;
      ten_d    = 1'b0;
    end else if (!clk_en) begin
      // frozen: every mclk-domain register keeps its value
      tgl_s_d  = tgl_s_q;
      idle_s_d = idle_s_q;
      tlr_s_d  = tlr_s_q;
      instr_d  = instr_q;
      opsel_d  = opsel_q;
      run_d    = run_q;
      ten_d    = ten_q;
    end
  end

  // mclk register group
  always_ff @(posedge mclk) begin
    tgl_s_q  <= tgl_s_d;
    idle_s_q <= idle_s_d;
    tlr_s_q  <= tlr_s_d;
    instr_q  <= instr_d;
    opsel_q  <= opsel_d;
    run_q    <= run_d;
    ten_q    <= ten_d;
  end

  assign instr_cur     = instr_q;
  assign test_op_sel   = opsel_q;
  assign test_op_run   = run_q;
  assign test_logic_en = ten_q;

endmodule : bstap_ctrl

// [bstap_ctrl_assertions.sv]
// concurrent checks on the ports of bstap_ctrl
// assumes tck stands low between frames and sys_rst is held across tck edges
`timescale 1ns/1ps
`include "bstap_defines.svh"
module bstap_ctrl_assertions (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        clk_en,
  input wire logic        tck,
  input wire logic        tms,
  input wire logic        tdi,
  input wire logic        tdo,
  input wire logic        tdo_oe,
  input wire logic [47:0] bnd_cells,
  input wire logic [7:0]  instr_cur,
  input wire logic [2:0]  test_op_sel,
  input wire logic        test_op_run,
  input wire logic        test_logic_en
);
  logic       oe_p_q;  // tdo_oe just before the last rising tck
  logic [3:0] ena_p_q; // enable cells just before the last rising tck
  // a rising edge must not move them, so the falling edge compares against this
  always_ff @(posedge tck) begin
    oe_p_q  <= tdo_oe;
    ena_p_q <= bnd_cells[47:44];
  end
  fall_only_a: assert property (
    @(negedge tck) disable iff (sys_rst) tdo_oe == oe_p_q && bnd_cells[47:44] == ena_p_q)
    else $error("link output moved on a rising edge");
  five_ones_a: assert property (
    @(posedge tck) disable iff (sys_rst) tms [*5] |=> !tdo_oe && bnd_cells[47:44] == 4'hF)
    else $error("five mode-select ones did not reach reset");
  oe_rise_a: assert property (
    @(posedge tck) disable iff (sys_rst) $rose(tdo_oe) |-> !$past(tms))
    else $error("tdo enabled without entering a shift state");
  oe_fall_a: assert property (
    @(posedge tck) disable iff (sys_rst) $fell(tdo_oe) |-> $past(tms))
    else $error("tdo released without leaving a shift state");
  oe_hold_a: assert property (
    @(posedge tck) disable iff (sys_rst) tdo_oe && !tms |=> tdo_oe)
    else $error("tdo released while still shifting");
  rst_vals_a: assert property (
    @(posedge mclk) $fell(sys_rst) |-> instr_cur == `BSTAP_IR_RESET
      && test_op_sel == `BSTAP_OPS_RESET && !test_op_run && !test_logic_en)
    else $error("wrong values out of reset");
  freeze_a: assert property (
    @(posedge mclk) disable iff (sys_rst) !clk_en |=> $stable(instr_cur) && $stable(test_op_sel))
    else $error("mclk side moved while frozen");
  run_en_a: assert property (
    @(posedge mclk) disable iff (sys_rst) test_op_run |-> test_logic_en)
    else $error("test operation running while logic is reset");
endmodule : bstap_ctrl_assertions

bind bstap_ctrl bstap_ctrl_assertions u_chk (.mclk, .sys_rst, .clk_en, .tck, .tms, .tdi, .tdo,
  .tdo_oe, .bnd_cells, .instr_cur, .test_op_sel, .test_op_run, .test_logic_en);

// [bstap_jtag_master.sv]
// test bus master model for the far side of the link
// assumes the controller samples on rising tck and drives on falling tck
`timescale 1ns/1ps
module bstap_jtag_master (
  output logic      tck,   // runs only inside frames, low between them
  output logic      tms,   // parked high after each scan, as a pullup would; run and step leave their last level
  output logic      tdi,   // parked high between frames, as a pullup would
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one 64 ns period; tdo is read just before the rising edge takes tms and tdi
  task automatic step(input logic m, input logic d, output logic o, output logic e);
    tms = m;
    tdi = d;
    #32;
    o = tdo;
    e = tdo_oe;
    tck = 1'b1;
    #32;
    tck = 1'b0;
  endtask : step
  // k periods with a fixed mode-select level, then let falling-edge updates land
  task automatic run(input logic m, input int k);
    logic o, e;
    for (int i = 0; i < k; i++) step(m, 1'b1, o, e);
    #1;
  endtask : run
  // one scan from idle back to idle; data goes lsb first
  task automatic scan(input logic ir, input int n, input logic [47:0] din,
                      output logic [47:0] dout, output logic oe_all);
    logic o, e;
    dout = '0;
    oe_all = 1'b1;
    step(1'b1, 1'b1, o, e);
    if (ir) step(1'b1, 1'b1, o, e);
    step(1'b0, 1'b1, o, e);
    step(1'b0, 1'b1, o, e);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o, e);
      dout[i] = o;
      oe_all &= e;
    end
    step(1'b1, 1'b1, o, e);
    step(1'b0, 1'b1, o, e);
    tms = 1'b1;
    tdi = 1'b1;
  endtask : scan
endmodule : bstap_jtag_master

// [bstap_ctrl_tb_top.sv]
// self-checking bench for bstap_ctrl driven through the test bus master model
// assumes the model owns the link pins and the bench owns the mclk side
`timescale 1ns/1ps
`include "bstap_defines.svh"
module bstap_ctrl_tb_top;
  localparam logic [31:0] ID_T = 32'h0000_5A5A; // arbitrary identity value
  localparam logic [47:0] PAT  = 48'h5A3C_96E1_0F7B;
  logic        mclk, sys_rst, clk_en, tck, tms, tdi, tdo, tdo_oe, test_op_run, test_logic_en;
  logic [47:0] bnd_cells, dq;
  logic [7:0]  instr_cur;
  logic [2:0]  test_op_sel;
  logic        oe;            // tdo_oe seen high through a whole shift
  int          num_errors   = 0;
  int          total_checks = 0;

  bstap_ctrl #(.ID_VALUE(ID_T)) DUT (.mclk, .sys_rst, .clk_en, .tck, .tms, .tdi, .tdo, .tdo_oe,
    .bnd_cells, .instr_cur, .test_op_sel, .test_op_run, .test_logic_en);
  bstap_jtag_master m (.tck, .tms, .tdi, .tdo, .tdo_oe);

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // covers the three-edge crossing into the mclk domain
  task automatic settle;
    repeat (6) @(negedge mclk);
  endtask : settle
  task automatic summarize;
    if (num_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  task automatic t_reset;
    chk(instr_cur, `BSTAP_IR_RESET);
    chk(test_op_sel, `BSTAP_OPS_RESET);
    chk(test_logic_en, 1'b0);
    chk(bnd_cells[47:44], 4'hF);
    chk(tdo_oe, 1'b0);
  endtask : t_reset
  task automatic t_idcode;
    m.run(1'b0, 3);
    settle();
    chk(test_op_run, 1'b1);
    chk(test_logic_en, 1'b1);
    m.scan(1'b0, 32, 48'h0, dq, oe);
    chk(dq[31:0], ID_T);
    chk(oe, 1'b1);
  endtask : t_idcode
  task automatic t_boundary;
    m.scan(1'b1, 8, 48'(`BSTAP_OP_BOUNDARY), dq, oe);
    chk(dq[7:0], `BSTAP_IR_CAPTURE);
    settle();
    chk(instr_cur, `BSTAP_OP_BOUNDARY);
    m.scan(1'b0, 48, PAT, dq, oe);
    chk(dq[47:44], 4'hF);
    chk(bnd_cells, PAT);
    m.scan(1'b0, 48, 48'h0, dq, oe);
    chk(dq, PAT);
  endtask : t_boundary
  task automatic t_ops_bypass;
    m.scan(1'b1, 8, 48'(`BSTAP_OP_OPSEL), dq, oe);
    m.scan(1'b0, 3, 48'h5, dq, oe);
    chk(dq[2:0], `BSTAP_OPS_RESET);
    settle();
    chk(test_op_sel, 3'h5);
    m.scan(1'b1, 8, 48'(`BSTAP_OP_BYPASS), dq, oe);
    m.scan(1'b0, 4, 48'hB, dq, oe);
    chk(dq[3:0], 4'h6);
  endtask : t_ops_bypass
  task automatic t_five_freeze;
    m.run(1'b1, 1);
    m.run(1'b0, 2);
    m.run(1'b1, 5);
    settle();
    chk(test_logic_en, 1'b0);
    chk(test_op_run, 1'b0);
    chk(instr_cur, `BSTAP_IR_RESET);
    chk(test_op_sel, `BSTAP_OPS_RESET);
    m.run(1'b0, 1);
    @(negedge mclk) clk_en = 1'b0;
    m.scan(1'b1, 8, 48'(`BSTAP_OP_BOUNDARY), dq, oe);
    settle();
    chk(instr_cur, `BSTAP_IR_RESET);
    @(negedge mclk) clk_en = 1'b1;
    settle();
    chk(instr_cur, `BSTAP_OP_BOUNDARY);
  endtask : t_five_freeze
  // instruction scan broken by a pause: no extra shift on the way back in
  task automatic t_pause;
    logic [7:0] op, q;
    logic       o, e;
    op = `BSTAP_OP_OPSEL;
    q  = '0;
    m.step(1'b1, 1'b1, o, e); // idle to select data path
    m.step(1'b1, 1'b1, o, e); // select instruction path
    m.step(1'b0, 1'b1, o, e); // capture
    m.step(1'b0, 1'b1, o, e); // shift
    for (int i = 0; i < 8; i++) begin
      m.step(i == 3 || i == 7, op[i], o, e);
      q[i] = o;
      if (i == 3) begin
        m.step(1'b0, 1'b1, o, e); // exit1 to pause
        chk(e, 1'b0);
        m.step(1'b1, 1'b1, o, e); // pause to exit2
        m.step(1'b0, 1'b1, o, e); // exit2 back to shift
      end
    end
    m.step(1'b1, 1'b1, o, e); // update
    m.step(1'b0, 1'b1, o, e); // idle
    chk(q, `BSTAP_IR_CAPTURE);
    settle();
    chk(instr_cur, `BSTAP_OP_OPSEL);
  endtask : t_pause

  // reset is held while tck runs, since the tap only sees it on tck edges
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    m.run(1'b1, 4);
    @(negedge mclk) sys_rst = 1'b0;
    @(negedge mclk);
    t_reset();
    m.run(1'b1, 5);
    t_idcode();
    t_boundary();
    t_ops_bypass();
    t_five_freeze();
    t_pause();
    summarize();
  end
  initial begin
    #2000000;
    num_errors++;
    summarize();
  end
endmodule : bstap_ctrl_tb_top
